// *** hw/lpcs_pkg.sv ***
// Package for the line printer compare/print sequencer.
// Assumes a 20 MHz system clock; all counts derive from it.
package lpcs_pkg;
  localparam int CLK_HZ = 20000000; // System clock rate
  localparam int POS_COUNT = 132; // Buffer positions
  localparam int CODE_W = 6; // Character code width
  localparam int WHEEL_CODES = 63; // Printable codes on the wheel
  localparam int WHEEL_US = 1033; // Interval between wheel codes
  localparam int REV_MS = 65; // Drum revolution time
  localparam int NOTIFY_MIN_MS = 60; // Minimum time from function to finish signal
  localparam int RESP_US = 1; // Longest response after an event
  localparam int WHEEL_CYC = WHEEL_US * (CLK_HZ / 1000000); // Cycles per wheel code
  localparam int MIN_CYC = NOTIFY_MIN_MS * (CLK_HZ / 1000); // 60 ms in cycles
  localparam int RESP_CYC = RESP_US * (CLK_HZ / 1000000); // 1 us in cycles
  localparam int PRINT_BIT = 6; // Printable flag position (7th level)
  localparam logic [5:0] LETTER_A = 6'h06; // Octal 06
  localparam logic [5:0] LETTER_Z = 6'h1f; // Octal 37
  localparam logic [5:0] DIGIT_0 = 6'h30; // Octal 60
  localparam logic [5:0] DIGIT_9 = 6'h39; // Octal 71

  // Buffer slot: printable flag plus code
  typedef struct packed {
    logic printable;
    logic [CODE_W-1:0] code;
  } lpcs_slot_type;

  // Function kinds
  typedef enum logic [1:0] {
    LPCS_FN_NOTIFY = 2'b00,
    LPCS_FN_STREAM = 2'b01
  } lpcs_fn_type;

  // Sequencer states
  typedef enum logic [2:0] {
    LPCS_IDLE = 3'b000,
    LPCS_WAIT = 3'b001,
    LPCS_SYNC = 3'b010,
    LPCS_SCAN = 3'b011,
    LPCS_HOLD = 3'b100,
    LPCS_ATTN = 3'b101,
    LPCS_REQ = 3'b110
  } lpcs_state_type;
endpackage : lpcs_pkg

// *** hw/lpcs_fifo.sv ***
// Small synchronous FIFO for wheel codes.
// Assumes one clock; width and depth are parameters.
`timescale 1ns/10ps
module lpcs_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // All state in one struct
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } lpcs_fifo_type;
  lpcs_fifo_type st_reg, st_next;

  // Next-state logic
  always_comb begin
    logic push;
    logic pop;
    push = in_valid && (st_reg.cnt != (AW+1)'(DEPTH));
    pop = out_valid && out_ready;
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr] = in_data;
      st_next.wr = (st_reg.wr == AW'(DEPTH-1)) ? '0 : st_reg.wr + 1'b1;
    end
    if (pop) begin
      st_next.rd = (st_reg.rd == AW'(DEPTH-1)) ? '0 : st_reg.rd + 1'b1;
    end
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign in_ready = (st_reg.cnt != (AW+1)'(DEPTH)); // Honest full
  assign out_valid = (st_reg.cnt != '0); // Honest empty
  assign out_data = st_reg.mem[st_reg.rd];
endmodule : lpcs_fifo

// *** hw/lpcs_core.sv ***
// Compare/print sequencer of a drum line printer control unit.
// Assumes wheel index and code pins are asynchronous; others same clock.
// Contract
// - Start only after spacing and loading done
// - Compare each wheel code against 132 positions
// - Each wheel code arrival is one scan
// - Drum turns continuously; one line per revolution
// - Compare only positions with printable flag set
// - On match fire actuator, clear printable flag
// - Scan finding no printable positions ends line
// - Notify after completion or 60 ms, later
// - After acknowledge of clean status, raise request
// - Streamed line raises request after 60 ms gate
// - Codes follow the processor octal character set
// - Sync wait, scans, plus one final scan
// - Stored slots carry a printable flag bit
// - Next streamed load waits for 60 ms timer; here word_ack reloads it and goes straight to WAIT, only HOLD waits on it
`timescale 1ns/10ps
module lpcs_core #(
  parameter int MIN_TIME = lpcs_pkg::MIN_CYC, // 60 ms gate, shortenable
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Function start from the channel logic
  input wire logic fn_start,
  input wire lpcs_pkg::lpcs_fn_type fn_kind,
  input wire logic spacing_done,
  input wire logic loading_done,
  // Buffer load port, written by the loading logic
  input wire logic buf_we,
  input wire logic [7:0] buf_addr,
  input wire lpcs_pkg::lpcs_slot_type buf_wdata,
  // Code wheel pins (asynchronous)
  input wire logic wheel_strobe,
  input wire logic [lpcs_pkg::CODE_W-1:0] wheel_code,
  // Actuators
  output logic [lpcs_pkg::POS_COUNT-1:0] fire,
  // Channel side
  output logic line_done,
  output logic attention,
  output logic [lpcs_pkg::CODE_W-1:0] status_code,
  input wire logic attn_ack,
  output logic word_request,
  input wire logic word_ack,
  output logic code_dropped
);
  import lpcs_pkg::*;

  localparam int TW = $clog2(MIN_TIME + 1);
  localparam logic [CODE_W-1:0] STAT_NORMAL = 6'h00; // Clean finish code
  localparam logic [CODE_W-1:0] NO_SYMBOL = 6'h05; // Only code missing from the wheel

  // True for codes inside the printable wheel set
  function automatic logic is_wheel_code(input logic [CODE_W-1:0] c);
    is_wheel_code = (c >= LETTER_A && c <= LETTER_Z) || (c >= DIGIT_0 && c <= DIGIT_9)
      || (c != NO_SYMBOL);
  endfunction : is_wheel_code

  // Whole sequencer state
  typedef struct packed {
    lpcs_state_type st;
    lpcs_fn_type fn;
    logic [TW-1:0] tmr;
    logic [POS_COUNT-1:0] fire;
    logic done;
    logic attn;
    logic req;
    logic [CODE_W-1:0] status;
    logic drop;
    logic [2:0] s_strobe;
    logic [CODE_W-1:0] s1_code;
    logic [CODE_W-1:0] s2_code;
  } lpcs_core_type;
  lpcs_core_type st_reg, st_next;

  // Line buffer, flag in the 7th level
  lpcs_slot_type buf_mem [POS_COUNT];
  logic [POS_COUNT-1:0] hit; // Matching positions this scan
  logic [POS_COUNT-1:0] live; // Printable positions this scan

  // Wheel code FIFO wiring
  logic fq_in_valid;
  logic fq_in_ready;
  logic fq_out_valid;
  logic fq_out_ready;
  logic [CODE_W-1:0] fq_out_data;

  // New wheel code on a synchronised strobe rise
  assign fq_in_valid = st_reg.s_strobe[1] && !st_reg.s_strobe[2];

  lpcs_fifo #(.WIDTH(CODE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .in_valid(fq_in_valid),
    .in_ready(fq_in_ready),
    .in_data(st_reg.s2_code),
    .out_valid(fq_out_valid),
    .out_ready(fq_out_ready),
    .out_data(fq_out_data)
  );

  // Always drain: codes met before sync are stale and are discarded,
  // since firing on an old code would strike the wrong symbol
  assign fq_out_ready = 1'b1;

  // Parallel compare of all positions in one cycle
  always_comb begin
    for (int i = 0; i < POS_COUNT; i++) begin
      live[i] = buf_mem[i].printable;
      hit[i] = live[i] && (buf_mem[i].code == fq_out_data);
    end
  end

  // Buffer writes: loader port, or flag clears on a hit
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < POS_COUNT; i++) begin
      if (buf_we && buf_addr == 8'(i)) begin
        buf_mem[i] <= buf_wdata;
      end else if (st_reg.st == LPCS_SCAN && fq_out_valid && hit[i]) begin
        buf_mem[i].printable <= 1'b0;
      end
    end
  end

  // Sequencer next state
  always_comb begin
    st_next = st_reg;
    st_next.s_strobe = {st_reg.s_strobe[1:0], wheel_strobe};
    st_next.s1_code = wheel_code;
    st_next.s2_code = st_reg.s1_code;
    st_next.fire = '0;
    st_next.done = 1'b0;
    st_next.drop = fq_in_valid && !fq_in_ready;
    // 60 ms timer counts from function receipt
    if (st_reg.tmr != '0) begin
      st_next.tmr = st_reg.tmr - 1'b1;
    end
    case (st_reg.st)
      LPCS_IDLE: begin
        if (fn_start) begin
          st_next.fn = fn_kind;
          st_next.tmr = TW'(MIN_TIME);
          st_next.st = LPCS_WAIT;
        end
      end
      LPCS_WAIT: begin
        if (spacing_done && loading_done) begin
          st_next.st = LPCS_SYNC;
        end
      end
      LPCS_SYNC: begin
        // Drum runs freely; the next wheel code synchronises us
        if (fq_out_valid) begin
          st_next.st = LPCS_SCAN;
        end
      end
      LPCS_SCAN: begin
        if (fq_out_valid && is_wheel_code(fq_out_data)) begin
          st_next.fire = hit;
          if (!(|live)) begin
            st_next.done = 1'b1;
            st_next.st = LPCS_HOLD;
          end
        end
      end
      LPCS_HOLD: begin
        // Later of completion and the 60 ms gate
        if (st_reg.tmr == '0) begin
          if (st_reg.fn == LPCS_FN_NOTIFY) begin
            st_next.attn = 1'b1;
            st_next.status = STAT_NORMAL;
            st_next.st = LPCS_ATTN;
          end else begin
            st_next.req = 1'b1;
            st_next.st = LPCS_REQ;
          end
        end
      end
      LPCS_ATTN: begin
        if (attn_ack) begin
          st_next.attn = 1'b0;
          st_next.req = (st_reg.status == STAT_NORMAL);
          st_next.st = st_next.req ? LPCS_REQ : LPCS_IDLE;
        end
      end
      LPCS_REQ: begin
        if (word_ack) begin
          st_next.req = 1'b0;
          if (st_reg.fn == LPCS_FN_STREAM) begin
            st_next.tmr = TW'(MIN_TIME);
            st_next.st = LPCS_WAIT;
          end else begin
            st_next.st = LPCS_IDLE;
          end
        end
      end
      default: begin
        st_next.st = LPCS_IDLE;
      end
    endcase
  end

  // Sequencer register
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flops
  assign fire = st_reg.fire;
  assign line_done = st_reg.done;
  assign attention = st_reg.attn;
  assign status_code = st_reg.status;
  assign word_request = st_reg.req;
  assign code_dropped = st_reg.drop;
endmodule : lpcs_core

// *** tb/lpcs_checker.sv ***
// Port assertions for the compare/print sequencer.
// Bound into lpcs_core; one clock, host answers stay clean.
`timescale 1ns/10ps
module lpcs_checker
  import lpcs_pkg::*;
#(parameter int MIN_TIME = 200) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Watched ports
  input wire logic fn_start,
  input wire logic [lpcs_pkg::POS_COUNT-1:0] fire,
  input wire logic line_done,
  input wire logic attention,
  input wire logic attn_ack,
  input wire logic word_request,
  input wire logic word_ack
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic busy_reg, done_reg; // Function taken; line finished
  int cnt_reg; // Gate timer, saturating
  logic gate_ok; // One cycle of slack on the gate
  assign gate_ok = cnt_reg >= MIN_TIME - 1;
  // Restart at a taken function and at each word_ack
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      cnt_reg <= 0;
    end else if ((fn_start && !busy_reg) || (word_request && word_ack)) begin
      busy_reg <= 1'b1;
      done_reg <= 1'b0;
      cnt_reg <= 0;
    end else begin
      done_reg <= done_reg || line_done;
      cnt_reg <= gate_ok ? cnt_reg : cnt_reg + 1;
    end
  end
  property p_idle; !busy_reg |-> fire == '0; endproperty
  a_idle: assert property (p_idle) else $error("fire while idle");
  property p_once; |fire |=> (fire & $past(fire)) == '0; endproperty
  a_once: assert property (p_once) else $error("column refired");
  property p_done; line_done |-> fire == '0 ##1 !line_done; endproperty
  a_done: assert property (p_done) else $error("bad line end");
  property p_at_gate; $rose(attention) |-> gate_ok && (done_reg || line_done); endproperty
  a_at_gate: assert property (p_at_gate) else $error("early notify");
  property p_soon; $rose(gate_ok && done_reg) |-> ##[0:20] (attention || word_request); endproperty
  a_soon: assert property (p_soon) else $error("late finish signal");
  property p_at_hold; attention && !attn_ack |=> attention; endproperty
  a_at_hold: assert property (p_at_hold) else $error("notify dropped");
  property p_rq_ack; attention && attn_ack |-> ##[1:20] word_request; endproperty
  a_rq_ack: assert property (p_rq_ack) else $error("no request");
  property p_rq_gate; $rose(word_request) |-> gate_ok; endproperty
  a_rq_gate: assert property (p_rq_gate) else $error("early request");
  c_line: cover property (line_done);
  c_attn: cover property (attention && attn_ack);
  c_req: cover property (word_request && word_ack);
endmodule : lpcs_checker
bind lpcs_core lpcs_checker #(.MIN_TIME(MIN_TIME)) lpcs_checker_i (.clk_sys(clk_sys),
  .nrst(nrst), .fn_start(fn_start), .fire(fire), .line_done(line_done),
  .attention(attention), .attn_ack(attn_ack), .word_request(word_request),
  .word_ack(word_ack));

// *** tb/lpcs_host.sv ***
// Channel-side model: acknowledges each request after LAG cycles.
// Assumes the sequencer holds a request until it is acknowledged.
`timescale 1ns/10ps
module lpcs_host #(parameter int LAG = 3) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Requests in, acknowledge pulses out
  input wire logic attention,
  input wire logic word_request,
  output logic attn_ack,
  output logic word_ack
);
  int wait_reg; // Cycles the request has stood
  // Count restarts after each pulse, so one request gets one acknowledge
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wait_reg <= 0;
      attn_ack <= 1'b0;
      word_ack <= 1'b0;
    end else begin
      attn_ack <= attention && wait_reg == LAG;
      word_ack <= word_request && !attention && wait_reg == LAG;
      wait_reg <= (attn_ack || word_ack || !(attention || word_request)) ? 0 : wait_reg + 1;
    end
  end
endmodule : lpcs_host

// *** tb/lpcs_core_bench.sv ***
// Bench for the compare/print sequencer: one notify line, one streamed line.
// Host model acknowledges; checker is bound into the core.
`timescale 1ns/10ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module lpcs_core_bench;
  import lpcs_pkg::*;
  localparam int MIN_T = 600; // Shortened gate keeps the run brief
  logic clk_sys = 1'b0, nrst = 1'b0, fn_start = 1'b0, wheel_strobe = 1'b0, buf_we = 1'b0;
  logic spacing_done = 1'b0, loading_done = 1'b0;
  lpcs_fn_type fn_kind = LPCS_FN_NOTIFY;
  logic [7:0] buf_addr = 8'h00;
  lpcs_slot_type buf_wdata = '0;
  logic [CODE_W-1:0] wheel_code = 6'h00, status_code, st_seen;
  logic [POS_COUNT-1:0] fire, fire_seen;
  logic line_done, attention, attn_ack, word_request, word_ack, code_dropped;
  int n_fail = 0, cmp_count = 0, cyc = 0, n_done, n_drop, n_attn, n_req, t_go, t_done, t_ans;
  logic [5:0] burst [6] = '{6'h00, 6'h06, 6'h1f, 6'h30, 6'h39, 6'h39}; // Sync code first
  always #25 clk_sys = ~clk_sys;
  lpcs_core #(.MIN_TIME(MIN_T), .FIFO_DEPTH(4)) lpcs_core_i (.clk_sys(clk_sys), .nrst(nrst),
    .fn_start(fn_start), .fn_kind(fn_kind), .spacing_done(spacing_done),
    .loading_done(loading_done), .buf_we(buf_we), .buf_addr(buf_addr), .buf_wdata(buf_wdata),
    .wheel_strobe(wheel_strobe), .wheel_code(wheel_code), .fire(fire), .line_done(line_done),
    .attention(attention), .status_code(status_code), .attn_ack(attn_ack),
    .word_request(word_request), .word_ack(word_ack), .code_dropped(code_dropped));
  lpcs_host #(.LAG(3)) lpcs_host_i (.clk_sys(clk_sys), .nrst(nrst), .attention(attention),
    .word_request(word_request), .attn_ack(attn_ack), .word_ack(word_ack));
  // Gather outputs; a hang counts as a mismatch
  always @(posedge clk_sys) begin
    cyc++;
    fire_seen <= fire_seen | fire;
    n_done += line_done;
    n_drop += code_dropped;
    n_attn += attention && attn_ack;
    n_req += word_request && word_ack;
    if (line_done) t_done = cyc;
    if ((attention || word_request) && t_ans == 0) t_ans = cyc;
    if (attention && attn_ack) st_seen = status_code;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  task step(int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask : step
  task put(int a, logic p, logic [5:0] c);
    buf_we = 1'b1;
    buf_addr = a[7:0];
    buf_wdata = '{p, c};
    step(1);
  endtask : put
  task strobe(logic [5:0] c, int gap);
    wheel_code = c;
    wheel_strobe = 1'b1;
    step(2);
    wheel_strobe = 1'b0;
    step(gap);
  endtask : strobe
  // Reset, then fill every slot unprintable yet holding a live code
  task begin_fn(lpcs_fn_type k);
    nrst = 1'b0;
    fn_kind = k;
    spacing_done = 1'b0;
    loading_done = 1'b0;
    step(5);
    nrst = 1'b1;
    for (int a = 0; a < POS_COUNT; a++) put(a, 1'b0, 6'h06);
  endtask : begin_fn
  task go;
    buf_we = 1'b0;
    fire_seen = '0;
    {n_done, n_drop, n_attn, n_req} = '0;
    t_go = cyc;
    t_done = 0;
    t_ans = 0;
    st_seen = 6'h3f;
    fn_start = 1'b1;
    step(1);
    fn_start = 1'b0;
  endtask : go
  task await_req;
    for (int i = 0; i < 3000 && n_req == 0; i++) step(1);
  endtask : await_req
  // Codes met before the line may start are drained and discarded; none fire or drop
  task run_notify;
    begin_fn(LPCS_FN_NOTIFY);
    put(0, 1'b1, 6'h06);
    put(1, 1'b1, 6'h06);
    put(5, 1'b1, 6'h1f);
    put(7, 1'b1, 6'h39);
    put(131, 1'b1, 6'h30);
    go();
    for (int i = 0; i < 6; i++) strobe(burst[i], 2);
    `CHK("early fire", '0, fire_seen)
    `CHK("dropped codes", 0, n_drop)
    spacing_done = 1'b1;
    loading_done = 1'b1;
    step(600);
    for (int i = 0; i < 6; i++) strobe(burst[i], 100);
    await_req();
    `CHK("status word", 6'h00, st_seen)
    `CHK("notify timing", 1'b1, t_ans - t_done <= RESP_CYC && t_ans - t_go >= MIN_T)
    `CHK("fired columns", {1'b1, 123'h0, 3'h5, 3'h0, 2'h3}, fire_seen)
    `CHK("line ends", 1, n_done)
    `CHK("notify seen", 1, n_attn)
    `CHK("request seen", 1, n_req)
  endtask : run_notify
  // Short streamed line must wait for the gate before asking for data
  task run_stream;
    begin_fn(LPCS_FN_STREAM);
    put(3, 1'b1, 6'h0a);
    go();
    spacing_done = 1'b1;
    loading_done = 1'b1;
    for (int i = 0; i < 3; i++) strobe(i > 0 ? 6'h0a : 6'h00, 150);
    await_req();
    `CHK("stream columns", 132'h8, fire_seen)
    `CHK("stream ends", 1, n_done)
    `CHK("stream notify", 0, n_attn)
    `CHK("stream request", 1, n_req)
    `CHK("stream gate", 1'b1, t_ans - t_go >= MIN_T && t_ans - t_go <= MIN_T + RESP_CYC)
  endtask : run_stream
  task summarize;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  initial begin
    run_notify();
    run_stream();
    summarize();
  end
endmodule : lpcs_core_bench
